//--- verilog/frs_pkg.sv
// Package for the fault restart sequencer: register map, field layout, states.
// Assumes a 32-bit APB slave on pclk at 25 MHz.
package frs_pkg;
    localparam logic [11:0] FRS_OFS_RESP   = 12'h000;
    localparam logic [11:0] FRS_OFS_UNIT   = 12'h004;
    localparam logic [11:0] FRS_OFS_CTRL   = 12'h008;
    localparam logic [11:0] FRS_OFS_STATUS = 12'h00C;
    localparam logic [11:0] FRS_OFS_IRQ    = 12'h010;
    localparam logic [11:0] FRS_OFS_MASK   = 12'h014;

    localparam int          FRS_RESP_HI    = 7;
    localparam int          FRS_RESP_LO    = 6;
    localparam int          FRS_RETRY_HI   = 5;
    localparam int          FRS_RETRY_LO   = 3;
    localparam int          FRS_MULT_HI    = 2;
    localparam int          FRS_MULT_LO    = 0;

    localparam logic [7:0]  FRS_RESP_RST   = 8'h00;
    localparam logic [15:0] FRS_UNIT_RST   = 16'h0001;
    localparam logic [2:0]  FRS_RETRY_NONE = 3'h0;
    localparam logic [2:0]  FRS_RETRY_INF  = 3'h7;

    // Control register bits
    localparam int          FRS_CTRL_CLR   = 0;
    localparam int          FRS_CTRL_ON    = 1;
    // Interrupt event bits
    localparam int          FRS_EV_FAULT   = 0;
    localparam int          FRS_EV_RETRY   = 1;
    localparam int          FRS_EV_LATCH   = 2;
    localparam int          FRS_NEV        = 3;

    localparam int          FRS_UNIT_W     = 16;
    localparam int          FRS_CNT_W      = 24;

    typedef enum logic [2:0] {
        FRS_IDLE   = 3'h0,
        FRS_GRACE  = 3'h1,
        FRS_WAIT   = 3'h2,
        FRS_TRY    = 3'h3,
        FRS_LATCH  = 3'h4
    } frs_state_t;

    typedef enum logic [1:0] {
        FRS_RSP_IGNORE  = 2'h0,
        FRS_RSP_DELAY   = 2'h1,
        FRS_RSP_RETRY   = 2'h2,
        FRS_RSP_LATCH   = 2'h3
    } frs_resp_t;

    // Delay in pclk cycles: 2**mult units of 'unit' cycles each
    function automatic logic [FRS_CNT_W-1:0] frs_delay(input logic [2:0] mult,
                                                       input logic [FRS_UNIT_W-1:0] unit);
        logic [FRS_CNT_W-1:0] u;
        u = {{(FRS_CNT_W-FRS_UNIT_W){1'b0}}, unit};
        return u << mult;
    endfunction
endpackage

//--- verilog/frs_sync.sv
// Two-flop synchroniser for asynchronous pin inputs.
// Assumes pclk domain; first flop read only by the second.
`timescale 1ns/1ps
module frs_sync (
    input  wire logic pclk,     // Clock
    input  wire logic presetn,  // Async reset, active low
    input  wire logic d,        // Asynchronous level
    output logic      q         // Synchronised level
);
    logic meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

//--- verilog/frs_sequencer.sv
// Fault restart sequencer: APB registers, retry state machine, interrupt.
// Assumes fault, control pin and bias-good arrive asynchronously from pins.
//
// Summary of operation
// - Retry code zero: no restart, output off until fault cleared.
// - Retry codes one to six give exactly that many restart attempts.
// - All attempts failed: output held off until the fault is cleared.
// - Interval between attempt starts is multiplier count times delay unit.
// - Retry code seven retries forever until bias loss or other fault; an off edge restarts the sequence, and attempts here go on with output held off.
// - Multiplier field selects two to the power of its value units.
// - Same delay serves grace time while operating and retry spacing.
// - Delay unit duration comes from a separate unit register.
// - Response bits choose ignore, delayed retry, disable-retry or latch-off.
// - Fault cleared by bit clear, clear command, reset, off-on cycle, bias loss.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module frs_sequencer
    import frs_pkg::*;
(
    input  wire logic        pclk,          // APB clock
    input  wire logic        presetn,       // Async reset, active low
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB enable
    input  wire logic        pwrite,        // APB direction
    input  wire logic [11:0] paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error
    input  wire logic        fault_in,      // Fault detector level, async
    input  wire logic        ctrl_pin,      // Remote on pin, high = on, async
    input  wire logic        bias_ok,       // Bias power good, async
    input  wire logic        other_shutdown,// Shutdown from another fault, same clock
    output logic             output_enable, // Converter output enable
    output logic             retrying,      // Restart attempt in progress
    output logic             irq            // Level interrupt
);
    typedef struct packed {
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        logic [7:0]            resp;
        logic [FRS_UNIT_W-1:0] unit;
        logic                  op_on;
        logic                  latched;
        logic [FRS_NEV-1:0]    ev;
        logic [FRS_NEV-1:0]    mask;
        frs_state_t            state;
        logic [2:0]            tries;
        logic [FRS_CNT_W-1:0]  timer;
        logic                  on_prev;
        logic                  out_en;
        logic                  retry;
        logic                  irq;
    } frs_regs_t;

    frs_regs_t r_reg, r_next;
    logic      fault_s, pin_s, bias_s;

    frs_sync u_sync_fault (.pclk(pclk), .presetn(presetn), .d(fault_in), .q(fault_s));
    frs_sync u_sync_pin   (.pclk(pclk), .presetn(presetn), .d(ctrl_pin), .q(pin_s));
    frs_sync u_sync_bias  (.pclk(pclk), .presetn(presetn), .d(bias_ok),  .q(bias_s));

    logic                 wr, rd, on_cmd, off_edge, on_edge, clear_req;
    logic [FRS_CNT_W-1:0] dly;
    logic [2:0]           retry_code;
    frs_resp_t            rsp;
    logic [FRS_NEV-1:0]   ev_set;

    always_comb begin
        r_next     = r_reg;
        ev_set     = '0;
        // Write lands on the edge where the master sees pready high
        wr         = psel && penable && pwrite && r_reg.pready;
        rd         = psel && !penable && !pwrite;
        on_cmd     = pin_s && r_reg.op_on;
        off_edge   = r_reg.on_prev && !on_cmd;
        on_edge    = !r_reg.on_prev && on_cmd;
        retry_code = r_reg.resp[FRS_RETRY_HI:FRS_RETRY_LO];
        rsp        = frs_resp_t'(r_reg.resp[FRS_RESP_HI:FRS_RESP_LO]);
        dly        = frs_delay(r_reg.resp[FRS_MULT_HI:FRS_MULT_LO], r_reg.unit);
        clear_req  = 1'b0;
        r_next.on_prev = on_cmd;

        // APB: one wait state, reads sampled in setup
        r_next.pready  = psel && penable && !r_reg.pready;
        r_next.pslverr = 1'b0;
        if (rd) begin
            unique case (paddr)
                FRS_OFS_RESP:   r_next.prdata = {24'h000000, r_reg.resp};
                FRS_OFS_UNIT:   r_next.prdata = {16'h0000, r_reg.unit};
                FRS_OFS_CTRL:   r_next.prdata = {30'h00000000, r_reg.op_on, 1'b0};
                FRS_OFS_STATUS: r_next.prdata = {24'h000000, r_reg.tries, r_reg.state, r_reg.latched, r_reg.out_en};
                FRS_OFS_IRQ:    r_next.prdata = {29'h00000000, r_reg.ev};
                FRS_OFS_MASK:   r_next.prdata = {29'h00000000, r_reg.mask};
                default:        r_next.prdata = 32'h00000000;
            endcase
        end
        if (psel && penable && !r_reg.pready) begin
            unique case (paddr)
                FRS_OFS_RESP, FRS_OFS_UNIT, FRS_OFS_CTRL,
                FRS_OFS_STATUS, FRS_OFS_IRQ, FRS_OFS_MASK: r_next.pslverr = 1'b0;
                default:                                   r_next.pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                FRS_OFS_RESP: r_next.resp = pwdata[7:0];
                FRS_OFS_UNIT: r_next.unit = pwdata[FRS_UNIT_W-1:0];
                FRS_OFS_CTRL: begin
                    r_next.op_on = pwdata[FRS_CTRL_ON];
                    clear_req    = pwdata[FRS_CTRL_CLR];
                end
                FRS_OFS_STATUS: clear_req = pwdata[0] && r_reg.latched;
                FRS_OFS_MASK: r_next.mask = pwdata[FRS_NEV-1:0];
                default: ;
            endcase
        end

        // Clearing resets counter and timer and returns to normal operation
        if (clear_req || off_edge || on_edge || !bias_s) begin
            r_next.latched = 1'b0;
            r_next.tries   = 3'h0;
            r_next.timer   = '0;
            r_next.state   = FRS_IDLE;
        end else if (other_shutdown && r_reg.state != FRS_IDLE) begin
            r_next.state   = FRS_LATCH;
            r_next.latched = 1'b1;
        end else begin
            unique case (r_reg.state)
                FRS_IDLE: begin
                    if (fault_s && rsp != FRS_RSP_IGNORE) begin
                        ev_set[FRS_EV_FAULT] = 1'b1;
                        r_next.tries = 3'h0;
                        r_next.timer = dly;
                        if (rsp == FRS_RSP_DELAY) r_next.state = FRS_GRACE;
                        else if (rsp == FRS_RSP_LATCH || retry_code == FRS_RETRY_NONE) begin
                            r_next.state   = FRS_LATCH;
                            r_next.latched = 1'b1;
                        end else r_next.state = FRS_WAIT;
                    end
                end
                FRS_GRACE: begin
                    // Output stays on during the grace time
                    if (!fault_s) r_next.state = FRS_IDLE;
                    else if (r_reg.timer > 1) r_next.timer = r_reg.timer - 1'b1;
                    else if (retry_code == FRS_RETRY_NONE) begin
                        r_next.state   = FRS_LATCH;
                        r_next.latched = 1'b1;
                    end else begin
                        r_next.timer = dly;
                        r_next.state = FRS_WAIT;
                    end
                end
                FRS_WAIT: begin
                    if (r_reg.timer > 1) r_next.timer = r_reg.timer - 1'b1;
                    else if (retry_code != FRS_RETRY_INF && r_reg.tries >= retry_code) begin
                        r_next.state   = FRS_LATCH;
                        r_next.latched = 1'b1;
                    end else begin
                        // Attempt starts; spacing counts from this start
                        ev_set[FRS_EV_RETRY] = 1'b1;
                        if (retry_code != FRS_RETRY_INF)
                            r_next.tries = r_reg.tries + 1'b1;
                        r_next.timer = dly;
                        r_next.state = FRS_TRY;
                    end
                end
                FRS_TRY: begin
                    // Fault gone after restart ends the sequence
                    if (!fault_s) r_next.state = FRS_IDLE;
                    else begin
                        r_next.state = FRS_WAIT;
                        if (r_reg.timer > 1) r_next.timer = r_reg.timer - 1'b1;
                    end
                end
                FRS_LATCH: r_next.latched = 1'b1;
                default: r_next.state = FRS_IDLE;
            endcase
        end
        if (r_next.state == FRS_LATCH && r_reg.state != FRS_LATCH)
            ev_set[FRS_EV_LATCH] = 1'b1;

        r_next.out_en = on_cmd && bias_s &&
                        (r_next.state == FRS_IDLE || r_next.state == FRS_GRACE || r_next.state == FRS_TRY);
        r_next.retry  = (r_next.state == FRS_TRY);
        // Set wins over a write-one clear in the same cycle
        if (wr && paddr == FRS_OFS_IRQ)
            r_next.ev = r_reg.ev & ~pwdata[FRS_NEV-1:0];
        r_next.ev  = r_next.ev | ev_set;
        r_next.irq = |(r_next.ev & r_next.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg         <= '0;
            r_reg.resp    <= FRS_RESP_RST;
            r_reg.unit    <= FRS_UNIT_RST;
            r_reg.op_on   <= 1'b1;
            r_reg.state   <= FRS_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata        = r_reg.prdata;
    assign pready        = r_reg.pready;
    assign pslverr       = r_reg.pslverr;
    assign output_enable = r_reg.out_en;
    assign retrying      = r_reg.retry;
    assign irq           = r_reg.irq;
endmodule

//--- tb/frs_chk.sv
// Checker: retry count, spacing and output-off relations.
// Assumes register writes land on the pready edge.
`timescale 1ns/1ps
module frs_chk
    import frs_pkg::*;
(
    input wire logic        pclk,           // Clock
    input wire logic        presetn,        // Reset
    input wire logic        psel,           // Select
    input wire logic        penable,        // Enable
    input wire logic        pwrite,         // Direction
    input wire logic        pready,         // Ready
    input wire logic [11:0] paddr,          // Address
    input wire logic [31:0] pwdata,         // Write data
    input wire logic        fault_in,       // Fault
    input wire logic        ctrl_pin,       // On pin
    input wire logic        bias_ok,        // Bias good
    input wire logic        other_shutdown, // Other fault
    input wire logic        output_enable,  // Output on
    input wire logic        retrying        // Attempt
);
    logic [7:0]  rsp;
    logic [15:0] unit;
    logic [23:0] gap;
    logic [2:0]  tries;
    logic        gap_ok;
    wire         wr   = psel && penable && pready && pwrite;
    wire         hold = fault_in && bias_ok && ctrl_pin && !wr;
    wire         run  = hold && !other_shutdown;
    wire  [23:0] dly  = {8'h00, unit} << rsp[2:0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow config; counts restart whenever the sequence may have been reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp    <= 8'h00;
            unit   <= 16'h0001;
            gap    <= 24'h0;
            tries  <= 3'h0;
            gap_ok <= 1'b0;
        end else begin
            if (wr && paddr == FRS_OFS_RESP) rsp <= pwdata[7:0];
            if (wr && paddr == FRS_OFS_UNIT) unit <= pwdata[15:0];
            gap    <= retrying ? 24'h1 : gap + 24'h1;
            gap_ok <= retrying || (gap_ok && hold);
            tries  <= hold ? tries + {2'h0, retrying} : 3'h0;
        end
    end
    sequence s_last;
        retrying && rsp[5:3] inside {[3'h1:3'h6]} && tries + 3'h1 == rsp[5:3];
    endsequence
    sequence s_hit;
        rsp[7:6] == 2'h1 && output_enable && $rose(fault_in);
    endsequence
    property p_gap; retrying && gap_ok |-> gap == dly; endproperty
    property p_cnt; retrying && rsp[5:3] inside {[3'h1:3'h6]} |-> tries < rsp[5:3]; endproperty
    property p_off; s_last |-> ##3 (!output_enable || !hold) [*8]; endproperty
    property p_none; rsp[5:3] == 3'h0 |-> !retrying; endproperty
    property p_ign; rsp[7:6] == 2'h0 |-> !retrying; endproperty
    property p_inf; retrying && rsp[5:3] == 3'h7 && run |-> ##[2:300] (retrying || !run); endproperty
    property p_bias; !bias_ok [*5] |-> !output_enable; endproperty
    property p_grace; s_hit |=> output_enable [*2]; endproperty
    a_gap: assert property (p_gap) else $error("attempt spacing wrong");
    a_cnt: assert property (p_cnt) else $error("too many attempts");
    a_off: assert property (p_off) else $error("output on after last attempt");
    a_none: assert property (p_none) else $error("attempt with retry code zero");
    a_ign: assert property (p_ign) else $error("attempt in ignore mode");
    a_inf: assert property (p_inf) else $error("endless retry stopped");
    a_bias: assert property (p_bias) else $error("output on without bias");
    a_grace: assert property (p_grace) else $error("output dropped in grace");
endmodule
bind frs_sequencer frs_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .paddr(paddr), .pwdata(pwdata), .fault_in(fault_in), .ctrl_pin(ctrl_pin), .bias_ok(bias_ok),
    .other_shutdown(other_shutdown), .output_enable(output_enable), .retrying(retrying));

//--- tb/frs_host.sv
// APB host model that programs and clears the sequencer.
// Assumes one transfer at a time; waits on pready without a cycle count.
`timescale 1ns/1ps
module frs_host (
    input  wire logic        pclk,    // Clock
    input  wire logic        pready,  // Ready
    input  wire logic [31:0] prdata,  // Read data
    input  wire logic        pslverr, // Error
    output logic             psel,    // Select
    output logic             penable, // Enable
    output logic             pwrite,  // Direction
    output logic      [11:0] paddr,   // Address
    output logic      [31:0] pwdata   // Write data
);
    logic err;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // Clear commands travel as ordinary writes
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

//--- tb/frs_sequencer_tb_top.sv
// Bench: register tasks plus fault and pin stimulus for the sequencer.
// Assumes delay unit counted in pclk cycles.
`timescale 1ns/1ps
module frs_sequencer_tb_top;
    import frs_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, fault_in = 1'b0;
    logic        ctrl_pin = 1'b1, bias_ok = 1'b1, other_shutdown = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, output_enable, retrying, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    int          fails = 0, cmp_count = 0, pulses = 0, p0, n;
    always #20 pclk = ~pclk;
    always @(posedge pclk) if (retrying === 1'b1) pulses <= pulses + 1;
    frs_host host_u (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    frs_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_in(fault_in),
        .ctrl_pin(ctrl_pin), .bias_ok(bias_ok), .other_shutdown(other_shutdown), .output_enable(output_enable),
        .retrying(retrying), .irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        host_u.xfer(1'b1, a, v, d);
    endtask
    task automatic rd(input logic [11:0] a);
        host_u.xfer(1'b0, a, 32'h0, d);
    endtask
    task automatic seq(input logic [7:0] r, input int e);
        int k;
        wr(FRS_OFS_RESP, {24'h0, r});
        p0 = pulses;
        fault_in <= 1'b1;
        rd(FRS_OFS_STATUS);
        for (k = 0; k < 150 && d[1] !== 1'b1; k++) rd(FRS_OFS_STATUS);
        chk(32'(pulses - p0), 32'(e));
        chk({29'h0, d[7:5]}, 32'(e));
        chk({31'h0, output_enable}, 32'h0);
        fault_in <= 1'b0;
    endtask
    task automatic post;
        repeat (6) @(posedge pclk);
        rd(FRS_OFS_STATUS);
        chk(d & 32'hE2, 32'h0);
        chk({31'h0, output_enable}, 32'h1);
    endtask
    task automatic stop_test;
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #2000000;
        fails++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(FRS_OFS_RESP);
        chk(d, 32'h0);
        rd(FRS_OFS_UNIT);
        chk(d, 32'h1);
        rd(12'h040);
        chk({d[31:1], host_u.err}, 32'h1);
        wr(FRS_OFS_UNIT, 32'h2);
        wr(FRS_OFS_MASK, 32'h4);
        for (n = 0; n < 7; n++) begin
            seq({2'h2, n[2:0], 3'h1}, n);
            chk({31'h0, irq}, 32'h1);
            wr(FRS_OFS_IRQ, 32'h4);
            @(posedge pclk);
            chk({31'h0, irq}, 32'h0);
            wr(FRS_OFS_STATUS, 32'h1);
            post();
            $display("Test retry code %0d done", n);
        end
        wr(FRS_OFS_RESP, 32'h11);
        p0 = pulses;
        fault_in <= 1'b1;
        repeat (30) @(posedge pclk);
        chk({31'h0, output_enable} | 32'(pulses - p0), 32'h1);
        fault_in <= 1'b0;
        wr(FRS_OFS_RESP, 32'h52);
        fault_in <= 1'b1;
        repeat (5) @(posedge pclk);
        fault_in <= 1'b0;
        repeat (30) @(posedge pclk);
        chk({31'h0, output_enable} | 32'(pulses - p0), 32'h1);
        seq(8'h52, 2);
        wr(FRS_OFS_CTRL, 32'h3);
        post();
        seq(8'hC9, 0);
        ctrl_pin <= 1'b0;
        repeat (5) @(posedge pclk);
        ctrl_pin <= 1'b1;
        post();
        $display("Test modes done");
        wr(FRS_OFS_MASK, 32'h0);
        wr(FRS_OFS_RESP, 32'hB8);
        p0 = pulses;
        fault_in <= 1'b1;
        repeat (60) @(posedge pclk);
        chk(32'(pulses - p0 > 10), 32'h1);
        other_shutdown <= 1'b1;
        repeat (5) @(posedge pclk);
        rd(FRS_OFS_STATUS);
        chk({30'h0, d[1], irq}, 32'h2);
        rd(FRS_OFS_IRQ);
        chk(d, 32'h7);
        other_shutdown <= 1'b0;
        fault_in <= 1'b0;
        bias_ok <= 1'b0;
        repeat (8) @(posedge pclk);
        bias_ok <= 1'b1;
        post();
        $display("Test endless retry done");
        stop_test();
    end
endmodule
